// *** src/capture_pkg.sv ***
// Constants for the dual position capture unit
package capture_pkg;
    localparam logic [15:0] ADDR_CAP_STATUS   = 16'h0a02;
    localparam logic [15:0] ADDR_A_EDGE       = 16'h0900;
    localparam logic [15:0] ADDR_B_EDGE       = 16'h0a06;
    localparam logic [15:0] ADDR_A_START_STOP = 16'h0a08;
    localparam logic [15:0] ADDR_B_START_STOP = 16'h0a0a;
    localparam logic [15:0] ADDR_A_POS_LO     = 16'h0a0c;
    localparam logic [15:0] ADDR_A_POS_HI     = 16'h0a0d;
    localparam logic [15:0] ADDR_B_POS_LO     = 16'h0a0e;
    localparam logic [15:0] ADDR_B_POS_HI     = 16'h0a0f;
    localparam logic [15:0] ADDR_A_COUNT      = 16'h0a10;
    localparam logic [15:0] ADDR_B_COUNT      = 16'h0a12;

    localparam int FILTER_TIME_NS  = 2000;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int FILTER_CYCLES   = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_W        = 6;

    localparam logic       EDGE_SELECT_RESET = 1'b0;
    localparam logic [1:0] START_STOP_RESET  = 2'h0;
    localparam logic [1:0] MODE_ABORT        = 2'h0;
    localparam logic [1:0] MODE_SINGLE       = 2'h1;
    localparam logic [1:0] MODE_CONTINUOUS   = 2'h2;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ARMED_SINGLE = 2'b01,
        CH_ARMED_CONT = 2'b10,
        CH_DONE = 2'b11
    } ch_state_type;
endpackage

// *** src/capture_channel.sv ***
// One capture channel: sync, filter, edge detect, latch, count
`timescale 1ns/1ps
`default_nettype none
module capture_channel (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        capture_pin,
    input  wire logic        edge_rising,
    input  wire logic        arm_write,
    input  wire logic [1:0]  arm_mode,
    input  wire logic [31:0] motor_position,
    output logic [31:0]      captured_position,
    output logic [15:0]      event_counter,
    output logic             done,
    output logic             running,
    output logic             capture_pulse
);
    logic                             sync1, sync2, filt, filt_q;
    logic [capture_pkg::FILTER_W-1:0] fcnt;
    capture_pkg::ch_state_type        state;
    logic                             next_sync1, next_sync2, next_filt, next_filt_q;
    logic [capture_pkg::FILTER_W-1:0] next_fcnt;
    capture_pkg::ch_state_type        next_state;
    logic [31:0]                      next_pos;
    logic [15:0]                      next_cnt;
    logic                             next_done, hit, edge_seen;

    always_comb begin
        next_sync1 = capture_pin;
        next_sync2 = sync1;
        next_filt = filt;
        next_fcnt = fcnt;
        if (sync2 == filt) begin
            next_fcnt = '0;
        end else if (fcnt == 6'(capture_pkg::FILTER_CYCLES - 1)) begin
            next_filt = sync2;
            next_fcnt = '0;
        end else begin
            next_fcnt = fcnt + 6'h01;
        end
        next_filt_q = filt;
        edge_seen = edge_rising ? (filt & ~filt_q) : (~filt & filt_q);
        hit = edge_seen && (state == capture_pkg::CH_ARMED_SINGLE ||
                            state == capture_pkg::CH_ARMED_CONT);
        next_state = state;
        next_pos = captured_position;
        next_cnt = event_counter;
        next_done = done;
        if (arm_write) begin
            case (arm_mode)
                capture_pkg::MODE_SINGLE: begin
                    next_state = capture_pkg::CH_ARMED_SINGLE;
                    next_cnt = '0;
                    next_done = 1'b0;
                end
                capture_pkg::MODE_CONTINUOUS: begin
                    next_state = capture_pkg::CH_ARMED_CONT;
                    next_cnt = '0;
                    next_done = 1'b0;
                end
                default: next_state = capture_pkg::CH_IDLE;
            endcase
        end else if (hit) begin
            next_pos = motor_position;
            next_cnt = event_counter + 16'h0001;
            next_done = 1'b1;
            if (state == capture_pkg::CH_ARMED_SINGLE) begin
                next_state = capture_pkg::CH_DONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            filt <= 1'b0;
            filt_q <= 1'b0;
            fcnt <= '0;
            state <= capture_pkg::CH_IDLE;
            captured_position <= '0;
            event_counter <= '0;
            done <= 1'b0;
        end else if (clk_en) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            filt <= next_filt;
            filt_q <= next_filt_q;
            fcnt <= next_fcnt;
            state <= next_state;
            captured_position <= next_pos;
            event_counter <= next_cnt;
            done <= next_done;
        end
    end

    assign running = (state == capture_pkg::CH_ARMED_SINGLE) ||
                     (state == capture_pkg::CH_ARMED_CONT);
    assign capture_pulse = hit && !arm_write && clk_en;

    single_stops_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && hit && !arm_write && state == capture_pkg::CH_ARMED_SINGLE
        |=> state == capture_pkg::CH_DONE) else $error("single shot not ended");
    latch_pos_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        capture_pulse |=> captured_position == $past(motor_position)
        && event_counter == $past(event_counter) + 16'h0001)
        else $error("capture latch or count wrong");
    idle_ignores_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && !arm_write && !running |=> $stable(captured_position)
        && $stable(event_counter)) else $error("idle channel changed");
    arm_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && arm_write && arm_mode != capture_pkg::MODE_ABORT
        && arm_mode != 2'h3 |=> event_counter == 16'h0000 && running)
        else $error("arm did not clear count");
endmodule
`default_nettype wire

// *** src/dual_position_capture_unit.sv ***
// Two-channel position capture with parameter register port
// Functional notes
// - Two capture channels run independently, each with its own input, settings and result.
// - A detected edge latches the current motor position as the channel result.
// - Edge select 0 triggers on falling edges and 1 on rising edges.
// - Writing 1 to start/stop arms a single-shot capture.
// - Writing 2 to start/stop arms continuous capture until stopped.
// - Continuous mode overwrites the captured position on every qualifying edge.
// - Single-shot mode ends at the first qualifying edge.
// - Writing 0 to start/stop aborts the capture function.
// - Arming is accepted only while the control source is the fieldbus.
// - Each capture input is filtered over about two microseconds.
// - Each channel counts its capture events in a read-only counter.
// - The event counter clears whenever the channel is armed.
// - A read-only status word shows completion in bit 0 and bit 1.
`timescale 1ns/1ps
`default_nettype none
module dual_position_capture_unit (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        capture_input_a,
    input  wire logic        capture_input_b,
    input  wire logic [31:0] motor_position,
    input  wire logic        source_is_fieldbus,
    input  wire logic        param_write,
    input  wire logic        param_read,
    input  wire logic [15:0] param_addr,
    input  wire logic [15:0] param_wdata,
    output logic [15:0]      param_rdata,
    output logic             param_error,
    output logic             capture_a_running,
    output logic             capture_b_running
);
    logic        capture_a_edge_select, capture_b_edge_select;
    logic [1:0]  capture_a_start_stop, capture_b_start_stop;
    logic        next_a_edge, next_b_edge;
    logic [1:0]  next_a_ss, next_b_ss;
    logic [15:0] next_rdata;
    logic        next_error;
    logic        arm_a, arm_b, wr_ok, sel_a_ss, sel_b_ss, legal_mode;
    logic [31:0] pos_a, pos_b;
    logic [15:0] capture_a_event_counter, capture_b_event_counter;
    logic        done_a, done_b, pulse_a, pulse_b;
    logic [15:0] capture_done_flags;

    capture_channel chan_a (
        .core_clk          (core_clk),
        .rst_n             (rst_n),
        .clk_en            (clk_en),
        .capture_pin       (capture_input_a),
        .edge_rising       (capture_a_edge_select),
        .arm_write         (arm_a),
        .arm_mode          (param_wdata[1:0]),
        .motor_position    (motor_position),
        .captured_position (pos_a),
        .event_counter     (capture_a_event_counter),
        .done              (done_a),
        .running           (capture_a_running),
        .capture_pulse     (pulse_a)
    );

    capture_channel chan_b (
        .core_clk          (core_clk),
        .rst_n             (rst_n),
        .clk_en            (clk_en),
        .capture_pin       (capture_input_b),
        .edge_rising       (capture_b_edge_select),
        .arm_write         (arm_b),
        .arm_mode          (param_wdata[1:0]),
        .motor_position    (motor_position),
        .captured_position (pos_b),
        .event_counter     (capture_b_event_counter),
        .done              (done_b),
        .running           (capture_b_running),
        .capture_pulse     (pulse_b)
    );

    assign capture_done_flags = {14'h0000, done_b, done_a};

    always_comb begin
        legal_mode = (param_wdata[15:2] == 14'h0000) && (param_wdata[1:0] != 2'h3);
        // Arming refused unless fieldbus owns control; abort always allowed
        wr_ok = legal_mode && (source_is_fieldbus ||
                param_wdata[1:0] == capture_pkg::MODE_ABORT);
        sel_a_ss = param_addr == capture_pkg::ADDR_A_START_STOP;
        sel_b_ss = param_addr == capture_pkg::ADDR_B_START_STOP;
        arm_a = param_write && sel_a_ss && wr_ok;
        arm_b = param_write && sel_b_ss && wr_ok;
        next_a_edge = capture_a_edge_select;
        next_b_edge = capture_b_edge_select;
        next_a_ss = capture_a_start_stop;
        next_b_ss = capture_b_start_stop;
        // Single shot falls back to abort once done
        if (pulse_a && capture_a_start_stop == capture_pkg::MODE_SINGLE) begin
            next_a_ss = capture_pkg::MODE_ABORT;
        end
        if (pulse_b && capture_b_start_stop == capture_pkg::MODE_SINGLE) begin
            next_b_ss = capture_pkg::MODE_ABORT;
        end
        if (arm_a) begin
            next_a_ss = param_wdata[1:0];
        end
        if (arm_b) begin
            next_b_ss = param_wdata[1:0];
        end
        next_error = 1'b0;
        if (param_write) begin
            case (param_addr)
                capture_pkg::ADDR_A_EDGE: begin
                    if (param_wdata[15:1] == 15'h0000) begin
                        next_a_edge = param_wdata[0];
                    end else begin
                        next_error = 1'b1;
                    end
                end
                capture_pkg::ADDR_B_EDGE: begin
                    if (param_wdata[15:1] == 15'h0000) begin
                        next_b_edge = param_wdata[0];
                    end else begin
                        next_error = 1'b1;
                    end
                end
                capture_pkg::ADDR_A_START_STOP: next_error = !wr_ok;
                capture_pkg::ADDR_B_START_STOP: next_error = !wr_ok;
                default: next_error = 1'b1;
            endcase
        end
        next_rdata = 16'h0000;
        if (param_read) begin
            case (param_addr)
                capture_pkg::ADDR_CAP_STATUS:   next_rdata = capture_done_flags;
                capture_pkg::ADDR_A_EDGE:       next_rdata = {15'h0000, capture_a_edge_select};
                capture_pkg::ADDR_B_EDGE:       next_rdata = {15'h0000, capture_b_edge_select};
                capture_pkg::ADDR_A_START_STOP: next_rdata = {14'h0000, capture_a_start_stop};
                capture_pkg::ADDR_B_START_STOP: next_rdata = {14'h0000, capture_b_start_stop};
                capture_pkg::ADDR_A_POS_LO:     next_rdata = pos_a[15:0];
                capture_pkg::ADDR_A_POS_HI:     next_rdata = pos_a[31:16];
                capture_pkg::ADDR_B_POS_LO:     next_rdata = pos_b[15:0];
                capture_pkg::ADDR_B_POS_HI:     next_rdata = pos_b[31:16];
                capture_pkg::ADDR_A_COUNT:      next_rdata = capture_a_event_counter;
                capture_pkg::ADDR_B_COUNT:      next_rdata = capture_b_event_counter;
                default: next_error = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            capture_a_edge_select <= capture_pkg::EDGE_SELECT_RESET;
            capture_b_edge_select <= capture_pkg::EDGE_SELECT_RESET;
            capture_a_start_stop <= capture_pkg::START_STOP_RESET;
            capture_b_start_stop <= capture_pkg::START_STOP_RESET;
            param_rdata <= 16'h0000;
            param_error <= 1'b0;
        end else if (clk_en) begin
            capture_a_edge_select <= next_a_edge;
            capture_b_edge_select <= next_b_edge;
            capture_a_start_stop <= next_a_ss;
            capture_b_start_stop <= next_b_ss;
            param_rdata <= next_rdata;
            param_error <= next_error;
        end
    end

    no_arm_local_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && param_write && !source_is_fieldbus && !capture_b_running
        |=> !capture_b_running) else $error("channel b armed without fieldbus");
    refuse_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && param_write && !source_is_fieldbus && !capture_a_running
        |=> !capture_a_running) else $error("channel a armed without fieldbus");
    abort_stops_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && param_write && sel_b_ss && param_wdata == 16'h0000
        |=> !capture_b_running) else $error("abort did not stop channel");
    cont_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && capture_b_running && capture_b_start_stop == capture_pkg::MODE_CONTINUOUS
        && pulse_b && !param_write |=> capture_b_running) else $error("continuous stopped");
    status_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && pulse_a |=> done_a ##0 capture_done_flags[0])
        else $error("status bit not set");
endmodule
`default_nettype wire

// *** dv/mark_sensor.sv ***
// Model of the two external mark sensors that drive the capture pins
`timescale 1ns/1ps
`default_nettype none
module mark_sensor (
    input  wire logic [1:0] level_req,
    output logic [1:0]      pins
);
    // Pins follow the request with a skew unrelated to the clock
    initial begin
        pins = 2'b00;
        forever begin
            @(level_req);
            pins <= #11 level_req;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the dual position capture unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk;
    logic        rst_n;
    logic        clk_en;
    logic [1:0]  level_req;
    logic [1:0]  pins;
    logic [31:0] motor_position;
    logic        source_is_fieldbus;
    logic        param_write;
    logic        param_read;
    logic [15:0] param_addr;
    logic [15:0] param_wdata;
    logic [15:0] param_rdata;
    logic        param_error;
    logic        capture_a_running;
    logic        capture_b_running;
    logic [16:0] exp_q[$];
    logic [16:0] exp_v;
    logic        was_acc;
    logic [15:0] addrs[11];
    logic [31:0] pos;
    int          n_mismatch;
    int          cmp_count;
    int          cycles;
    int          seed;

    mark_sensor sensor_u (.level_req(level_req), .pins(pins));

    dual_position_capture_unit dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .capture_input_a(pins[0]), .capture_input_b(pins[1]),
        .motor_position(motor_position), .source_is_fieldbus(source_is_fieldbus),
        .param_write(param_write), .param_read(param_read), .param_addr(param_addr),
        .param_wdata(param_wdata), .param_rdata(param_rdata), .param_error(param_error),
        .capture_a_running(capture_a_running), .capture_b_running(capture_b_running)
    );

    task automatic tally_and_finish;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic err, input logic [15:0] exp);
        @(posedge core_clk);
        #2;
        param_write = w;
        param_read = !w;
        param_addr = a;
        param_wdata = d;
        exp_q.push_back({err, exp});
        @(posedge core_clk);
        #2;
        param_write = 1'b0;
        param_read = 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic err);
        acc(1'b1, a, d, err, 16'h0000);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000, 1'b0, exp);
    endtask

    task automatic rd_pos(input logic ch_b, input logic [31:0] exp);
        rd(ch_b ? capture_pkg::ADDR_B_POS_LO : capture_pkg::ADDR_A_POS_LO, exp[15:0]);
        rd(ch_b ? capture_pkg::ADDR_B_POS_HI : capture_pkg::ADDR_A_POS_HI, exp[31:16]);
    endtask

    task automatic set_pin(input int ch, input logic v, input int n);
        level_req[ch] = v;
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    // Answer monitor: strobe seen at one falling edge, answer at the next
    always @(negedge core_clk) begin
        if (was_acc) begin
            exp_v = exp_q.pop_front();
            check({15'h0, param_error, param_rdata}, {15'h0, exp_v});
        end
        was_acc = param_write | param_read;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        level_req = 2'b00;
        motor_position = 32'h0000_0000;
        source_is_fieldbus = 1'b1;
        param_write = 1'b0;
        param_read = 1'b0;
        param_addr = 16'h0000;
        param_wdata = 16'h0000;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        was_acc = 1'b0;
        seed = 32'h29e5;
        addrs = '{capture_pkg::ADDR_CAP_STATUS, capture_pkg::ADDR_A_EDGE,
            capture_pkg::ADDR_B_EDGE, capture_pkg::ADDR_A_START_STOP,
            capture_pkg::ADDR_B_START_STOP, capture_pkg::ADDR_A_POS_LO,
            capture_pkg::ADDR_A_POS_HI, capture_pkg::ADDR_B_POS_LO,
            capture_pkg::ADDR_B_POS_HI, capture_pkg::ADDR_A_COUNT, capture_pkg::ADDR_B_COUNT};
        repeat (2) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        foreach (addrs[i]) rd(addrs[i], 16'h0000);
        // Refused accesses, then an abort that is accepted without fieldbus
        acc(1'b0, 16'h0a20, 16'h0000, 1'b1, 16'h0000);
        wr(capture_pkg::ADDR_CAP_STATUS, 16'h0001, 1'b1);
        wr(capture_pkg::ADDR_A_COUNT, 16'h0001, 1'b1);
        wr(capture_pkg::ADDR_A_EDGE, 16'h0002, 1'b1);
        wr(capture_pkg::ADDR_A_START_STOP, 16'h0003, 1'b1);
        source_is_fieldbus = 1'b0;
        wr(capture_pkg::ADDR_A_START_STOP, 16'h0001, 1'b1);
        wr(capture_pkg::ADDR_B_START_STOP, 16'h0002, 1'b1);
        check({31'h0, capture_a_running | capture_b_running}, 32'h0);
        wr(capture_pkg::ADDR_A_START_STOP, 16'h0000, 1'b0);
        source_is_fieldbus = 1'b1;
        // Channel A single shot on rising edge
        wr(capture_pkg::ADDR_A_EDGE, 16'h0001, 1'b0);
        rd(capture_pkg::ADDR_A_EDGE, 16'h0001);
        wr(capture_pkg::ADDR_A_START_STOP, 16'h0001, 1'b0);
        check({30'h0, capture_a_running, capture_b_running}, 32'h2);
        pos = $random(seed);
        motor_position = pos;
        set_pin(0, 1'b1, 60);
        check({31'h0, capture_a_running}, 32'h0);
        motor_position = ~pos;
        set_pin(0, 1'b0, 60);
        set_pin(0, 1'b1, 60);
        rd_pos(1'b0, pos);
        rd(capture_pkg::ADDR_A_COUNT, 16'h0001);
        rd(capture_pkg::ADDR_A_START_STOP, 16'h0000);
        rd(capture_pkg::ADDR_CAP_STATUS, 16'h0001);
        // Channel B continuous on falling edge
        set_pin(1, 1'b1, 60);
        wr(capture_pkg::ADDR_B_START_STOP, 16'h0002, 1'b0);
        for (int k = 1; k <= 3; k++) begin
            pos = $random(seed);
            motor_position = pos;
            set_pin(1, 1'b0, 60);
            rd_pos(1'b1, pos);
            set_pin(1, 1'b1, 60);
            rd(capture_pkg::ADDR_B_COUNT, k[15:0]);
        end
        set_pin(1, 1'b0, 10);
        set_pin(1, 1'b1, 60);
        rd(capture_pkg::ADDR_B_COUNT, 16'h0003);
        check({31'h0, capture_b_running}, 32'h1);
        rd(capture_pkg::ADDR_CAP_STATUS, 16'h0003);
        wr(capture_pkg::ADDR_B_START_STOP, 16'h0000, 1'b0);
        check({31'h0, capture_b_running}, 32'h0);
        set_pin(1, 1'b0, 60);
        rd(capture_pkg::ADDR_B_COUNT, 16'h0003);
        rd_pos(1'b1, pos);
        wr(capture_pkg::ADDR_B_START_STOP, 16'h0001, 1'b0);
        rd(capture_pkg::ADDR_B_COUNT, 16'h0000);
        rd(capture_pkg::ADDR_CAP_STATUS, 16'h0001);
        rd(capture_pkg::ADDR_A_COUNT, 16'h0001);
        // Edges while the clock enable is low are never seen
        wr(capture_pkg::ADDR_B_EDGE, 16'h0001, 1'b0);
        rd(capture_pkg::ADDR_B_EDGE, 16'h0001);
        clk_en = 1'b0;
        set_pin(1, 1'b1, 60);
        set_pin(1, 1'b0, 60);
        clk_en = 1'b1;
        set_pin(1, 1'b0, 60);
        check({31'h0, capture_b_running}, 32'h1);
        rd(capture_pkg::ADDR_B_COUNT, 16'h0000);
        pos = $random(seed);
        motor_position = pos;
        set_pin(1, 1'b1, 60);
        check({31'h0, capture_b_running}, 32'h0);
        rd_pos(1'b1, pos);
        rd(capture_pkg::ADDR_B_COUNT, 16'h0001);
        tally_and_finish();
    end
endmodule
`default_nettype wire
